// *** hdl/chg_pkg.sv ***
// Constants for the charger thermistor status and gating block
package chg_pkg;
	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_MODE = 8'h04;
	localparam logic [7:0] ADDR_IRQ = 8'h08;
	localparam logic [7:0] ADDR_MASK = 8'h0C;
	localparam logic [7:0] ADDR_TOFF = 8'h10;
	// Status word fields
	localparam int ST_OVER = 0;
	localparam int ST_COLD = 1;
	localparam int ST_HOT = 2;
	localparam int ST_SHORT = 3;
	localparam int ST_HOTLATCH = 4;
	localparam int ST_CHARGE = 5;
	localparam int ST_PFAIL = 13;
	localparam int ST_PACK_VOLTAGE = 14;
	localparam int ST_AC = 15;
	// Mode fields
	localparam int MD_HOTSTOP = 0;
	localparam int MD_VARIANT = 1;
	localparam int MD_PORREQ = 2;
	localparam int MD_CHGEN = 3;
	localparam logic [31:0] MODE_RESET = 32'h00000009;
	localparam logic [31:0] MASK_RESET = 32'h00000000;
	localparam logic [31:0] TOFF_RESET = 32'h00000019;
	// Idle levels of the watched status bits: only power fail sits high
	localparam logic [2:0] EV_IDLE = 3'h1;
	// Thresholds as printed
	localparam int OVER_KOHM = 100;
	localparam int COLD_KOHM = 30;
	localparam int HOT_KOHM = 3;
	localparam int SHORT_OHM = 500;
	localparam int SRC_ON_MV = 300;
	localparam int SRC_OFF_MV = 100;
	localparam int LOAD_OFF_MV = 100;
	localparam int LOAD_ON_MV = 300;
	// Timing
	localparam int CLK_MHZ = 25;
	localparam int MAX_ON_MS = 10;
	localparam int MIN_OFF_US = 1;
	localparam int MAX_ON_CYC = MAX_ON_MS * 1000 * CLK_MHZ;
	localparam int MIN_OFF_CYC = MIN_OFF_US * CLK_MHZ;
endpackage

// *** hdl/charger_status_gate.sv ***
// Thermistor status, switch drives and converter on/off timing of the charger
`timescale 1ns/1ps
module charger_status_gate #(
	parameter int MAX_ON_CYCLES = chg_pkg::MAX_ON_CYC,
	parameter int MIN_OFF_CYCLES = chg_pkg::MIN_OFF_CYC
) (
	// APB
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Thermistor comparators, high when resistance beyond threshold
	input wire logic temp_over_cmp,
	input wire logic temp_cold_cmp,
	input wire logic temp_hot_cmp,
	input wire logic temp_short_cmp,
	// Adapter versus pack comparators
	input wire logic src_on_cmp,
	input wire logic src_off_cmp,
	input wire logic load_off_cmp,
	input wire logic load_on_cmp,
	input wire logic adapter_present,
	// Converter current-loop request and off-time ramp
	input wire logic loop_on_req,
	input wire logic [7:0] pack_voltage_code,
	// Outputs
	output logic source_switch_drive,
	output logic load_switch_drive,
	output logic high_side_on,
	output logic charge_allowed,
	output logic irq
);
	// ****************************************
	// Parameter checks
	// ****************************************
	// The on/off counter is 25 bits wide
	if (MAX_ON_CYCLES < 2 || MIN_OFF_CYCLES < 1 ||
		MAX_ON_CYCLES > 33554431) begin : g_bad_timing
		$error("charger_status_gate: bad timing parameters");
	end

	// ****************************************
	// Input synchronisers
	// ****************************************
	localparam int NSYNC = 9;
	logic [NSYNC-1:0] raw_in;
	logic [NSYNC-1:0] sync_a;
	logic [NSYNC-1:0] sync_b;
	logic [NSYNC-1:0] sync_c;
	logic [NSYNC-1:0] clean;
	assign raw_in = {adapter_present, load_on_cmp, load_off_cmp, src_off_cmp, src_on_cmp,
		temp_short_cmp, temp_hot_cmp, temp_cold_cmp, temp_over_cmp};

	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					sync_a[gi] <= 1'b0;
					sync_b[gi] <= 1'b0;
					sync_c[gi] <= 1'b0;
					clean[gi] <= 1'b0;
				end else begin
					sync_a[gi] <= raw_in[gi];
					sync_b[gi] <= sync_a[gi];
					sync_c[gi] <= sync_b[gi];
					// Accept a change once two stages agree
					if (sync_b[gi] == sync_c[gi]) begin
						clean[gi] <= sync_c[gi];
					end
				end
			end
		end
	endgenerate

	logic t_over;
	logic t_cold;
	logic t_hot;
	logic t_short;
	logic c_src_on;
	logic c_src_off;
	logic c_load_off;
	logic c_load_on;
	logic ac_in;
	assign t_over = clean[0];
	assign t_cold = clean[1];
	assign t_hot = clean[2];
	assign t_short = clean[3];
	assign c_src_on = clean[4];
	assign c_src_off = clean[5];
	assign c_load_off = clean[6];
	assign c_load_on = clean[7];
	assign ac_in = clean[8];

	// ****************************************
	// Registers
	// ****************************************
	logic [31:0] mode;
	logic [2:0] mask;
	logic [2:0] irq_stat;
	logic [7:0] toff_base;
	logic hot_latch;
	logic pack_voltage_present;
	logic pwr_fail;
	logic [31:0] status;
	logic wr_acc;
	logic por_cmd;

	// Write access phase aimed at one register word
	function automatic logic wr_to(input logic acc, input logic [7:0] a, input logic [7:0] off);
		wr_to = acc && a == off;
	endfunction

	assign wr_acc = psel && penable && pwrite;
	assign por_cmd = wr_to(wr_acc, paddr, chg_pkg::ADDR_MODE) && pwdata[chg_pkg::MD_PORREQ];

	function automatic logic addr_ok(input logic [7:0] a);
		addr_ok = a == chg_pkg::ADDR_STATUS || a == chg_pkg::ADDR_MODE ||
			a == chg_pkg::ADDR_IRQ || a == chg_pkg::ADDR_MASK || a == chg_pkg::ADDR_TOFF;
	endfunction

	always_comb begin
		status = 32'h00000000;
		status[chg_pkg::ST_OVER] = t_over;
		status[chg_pkg::ST_COLD] = t_cold;
		status[chg_pkg::ST_HOT] = t_hot;
		status[chg_pkg::ST_SHORT] = t_short;
		status[chg_pkg::ST_HOTLATCH] = hot_latch;
		status[chg_pkg::ST_CHARGE] = charge_allowed;
		status[chg_pkg::ST_PFAIL] = pwr_fail;
		status[chg_pkg::ST_PACK_VOLTAGE] = pack_voltage_present;
		status[chg_pkg::ST_AC] = ac_in;
	end

	// Mode register; over-range or a reset request restores defaults
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode <= chg_pkg::MODE_RESET;
		end else if (t_over || por_cmd) begin
			mode <= chg_pkg::MODE_RESET;
		end else if (wr_to(wr_acc, paddr, chg_pkg::ADDR_MODE)) begin
			// Reset request is a strobe, never stored
			mode <= {28'h0000000, pwdata[chg_pkg::MD_CHGEN], 1'b0,
				pwdata[chg_pkg::MD_VARIANT], pwdata[chg_pkg::MD_HOTSTOP]};
		end
	end

	// Interrupt mask, restored together with the mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask <= chg_pkg::MASK_RESET[2:0];
		end else if (t_over || por_cmd) begin
			mask <= chg_pkg::MASK_RESET[2:0];
		end else if (wr_to(wr_acc, paddr, chg_pkg::ADDR_MASK)) begin
			mask <= pwdata[2:0];
		end
	end

	// Off-time base, restored together with the mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			toff_base <= chg_pkg::TOFF_RESET[7:0];
		end else if (t_over || por_cmd) begin
			toff_base <= chg_pkg::TOFF_RESET[7:0];
		end else if (wr_to(wr_acc, paddr, chg_pkg::ADDR_TOFF)) begin
			toff_base <= pwdata[7:0];
		end
	end

	// Hot latch and battery present
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hot_latch <= 1'b0;
			pack_voltage_present <= 1'b0;
		end else begin
			pack_voltage_present <= !t_over;
			if (t_hot) begin
				hot_latch <= 1'b1;
			end else if (t_over || por_cmd) begin
				hot_latch <= 1'b0;
			end
		end
	end

	// ****************************************
	// Source and load switches
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			source_switch_drive <= 1'b0;
			load_switch_drive <= 1'b1;
		end else begin
			if (c_src_on) begin
				source_switch_drive <= 1'b1;
			end else if (!c_src_off) begin
				source_switch_drive <= 1'b0;
			end
			if (c_load_off) begin
				load_switch_drive <= 1'b0;
			end else if (c_load_on) begin
				load_switch_drive <= 1'b1;
			end
		end
	end
	assign pwr_fail = !source_switch_drive;

	// ****************************************
	// Charge gating
	// ****************************************
	logic next_allow;
	always_comb begin
		next_allow = mode[chg_pkg::MD_CHGEN] && pack_voltage_present;
		if (hot_latch && mode[chg_pkg::MD_HOTSTOP]) begin
			// Alternate variant keeps charging a shorted sensor
			if (!(mode[chg_pkg::MD_VARIANT] && t_short)) begin
				next_allow = 1'b0;
			end
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			charge_allowed <= 1'b0;
		end else begin
			charge_allowed <= next_allow;
		end
	end

	// ****************************************
	// Converter on/off timing
	// ****************************************
	typedef enum logic [1:0] {
		PH_OFF = 2'b01,
		PH_ON = 2'b10
	} phase_t;
	phase_t phase;
	logic [24:0] tcount;
	logic [9:0] toff_cycles;
	// Off-time scales with pack voltage so ripple stays constant
	assign toff_cycles = 10'(toff_base) + 10'(pack_voltage_code);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase <= PH_OFF;
			tcount <= 25'h0000000;
			high_side_on <= 1'b0;
		end else begin
			case (phase)
				PH_OFF: begin
					if (tcount < 25'(MIN_OFF_CYCLES) || tcount < 25'(toff_cycles)) begin
						tcount <= tcount + 25'h0000001;
					end else if (loop_on_req && charge_allowed) begin
						phase <= PH_ON;
						tcount <= 25'h0000001;
						high_side_on <= 1'b1;
					end
				end
				PH_ON: begin
					if (!loop_on_req || !charge_allowed ||
						tcount >= 25'(MAX_ON_CYCLES)) begin
						phase <= PH_OFF;
						tcount <= 25'h0000001;
						high_side_on <= 1'b0;
					end else begin
						tcount <= tcount + 25'h0000001;
					end
				end
				default: begin
					phase <= PH_OFF;
					tcount <= 25'h0000000;
					high_side_on <= 1'b0;
				end
			endcase
		end
	end

	// ****************************************
	// Interrupts
	// ****************************************
	logic [2:0] ev_now;
	logic [2:0] ev_prev;
	logic [2:0] ev_chg;
	assign ev_now = {ac_in, pack_voltage_present, pwr_fail};
	assign ev_chg = ev_now ^ ev_prev;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// Start from the idle levels, so reset itself is no event
			ev_prev <= chg_pkg::EV_IDLE;
		end else begin
			ev_prev <= ev_now;
		end
	end

	// Set beats a simultaneous write-one clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat <= 3'h0;
		end else if (wr_to(wr_acc, paddr, chg_pkg::ADDR_IRQ)) begin
			irq_stat <= (irq_stat & ~pwdata[2:0]) | ev_chg;
		end else begin
			irq_stat <= irq_stat | ev_chg;
		end
	end

	// Level output, one cycle behind the status bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat & ~mask);
		end
	end

	// ****************************************
	// APB read
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			// Answer in the cycle after setup, never a wait state
			pready <= psel && !penable;
			pslverr <= psel && !penable && !addr_ok(paddr);
		end
	end

	// Read data is captured from the setup cycle's address
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				chg_pkg::ADDR_STATUS: prdata <= status;
				chg_pkg::ADDR_MODE: prdata <= mode;
				chg_pkg::ADDR_IRQ: prdata <= {29'h0, irq_stat};
				chg_pkg::ADDR_MASK: prdata <= {29'h0, mask};
				chg_pkg::ADDR_TOFF: prdata <= {24'h0, toff_base};
				default: prdata <= 32'h00000000;
			endcase
		end else begin
			prdata <= 32'h00000000;
		end
	end
endmodule

// *** tb/pack_comparators.sv ***
// Behavioural pack thermistor and adapter/pack voltage comparators
`timescale 1ns/1ps
module pack_comparators (
	// Analogue stimulus: thermistor ohms, adapter minus pack in mV
	input int therm_ohm,
	input int delta_mv,
	// Thermistor comparators
	output logic temp_over_cmp,
	output logic temp_cold_cmp,
	output logic temp_hot_cmp,
	output logic temp_short_cmp,
	// Adapter versus pack comparators
	output logic src_on_cmp,
	output logic src_off_cmp,
	output logic load_off_cmp,
	output logic load_on_cmp
);
	// ********
	// Ideal thresholds, no noise
	// ********
	assign temp_over_cmp = therm_ohm > 100000;
	assign temp_cold_cmp = therm_ohm > 30000;
	assign temp_hot_cmp = therm_ohm < 3000;
	assign temp_short_cmp = therm_ohm < 500;
	assign src_on_cmp = delta_mv >= 300;
	assign src_off_cmp = delta_mv > 100;
	assign load_off_cmp = delta_mv >= -100;
	assign load_on_cmp = delta_mv <= -300;
endmodule

// *** tb/charger_status_gate_asserts.sv ***
// Port checker for the charger status gate
`timescale 1ns/1ps
module charger_status_gate_asserts #(
	parameter int MAX_ON_CYCLES = 50,
	parameter int MIN_OFF_CYCLES = 25
) (
	// APB
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Comparators
	input wire logic src_on_cmp,
	input wire logic src_off_cmp,
	input wire logic load_off_cmp,
	input wire logic load_on_cmp,
	// Drives
	input wire logic source_switch_drive,
	input wire logic load_switch_drive,
	input wire logic high_side_on,
	input wire logic charge_allowed
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ********
	// Run lengths of the high-side drive
	// ********
	int on_cnt;
	int off_cnt;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			on_cnt <= 0;
			off_cnt <= 1000;
		end else begin
			on_cnt <= high_side_on ? on_cnt + 1 : 0;
			off_cnt <= high_side_on ? 0 : (off_cnt < 1000 ? off_cnt + 1 : off_cnt);
		end
	end
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_ready_setup: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	a_err_unmapped: assert property (pready && paddr > 8'h10 |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	a_src_holds_off: assert property ((!source_switch_drive && !src_on_cmp) [*6] |=>
		!source_switch_drive) else $error("source switch on without on level");
	a_src_holds_on: assert property ((source_switch_drive && src_off_cmp) [*6] |=>
		source_switch_drive) else $error("source switch off above off level");
	a_load_holds_on: assert property ((load_switch_drive && !load_off_cmp) [*6] |=>
		load_switch_drive) else $error("load switch off below off level");
	a_load_holds_off: assert property ((!load_switch_drive && !load_on_cmp) [*6] |=>
		!load_switch_drive) else $error("load switch on above on level");
	a_hs_gated: assert property (!charge_allowed [*2] |-> !high_side_on)
		else $error("high side on while charge blocked");
	a_max_on: assert property (high_side_on |-> on_cnt < MAX_ON_CYCLES)
		else $error("on time too long");
	a_min_off: assert property ($rose(high_side_on) |-> off_cnt >= MIN_OFF_CYCLES)
		else $error("off time too short");
	c_hs_on: cover property ($rose(high_side_on));
	c_src_off: cover property ($fell(source_switch_drive));
	c_refused: cover property (pslverr);
endmodule
bind charger_status_gate charger_status_gate_asserts #(.MAX_ON_CYCLES(MAX_ON_CYCLES),
	.MIN_OFF_CYCLES(MIN_OFF_CYCLES)) chk_i (.pclk, .presetn, .psel, .penable, .paddr, .prdata,
	.pready, .pslverr, .src_on_cmp, .src_off_cmp, .load_off_cmp, .load_on_cmp,
	.source_switch_drive, .load_switch_drive, .high_side_on, .charge_allowed);

// *** tb/test_charger_status_gate.sv ***
// Self-checking bench for the charger status gate
`timescale 1ns/1ps
module test_charger_status_gate;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00, pack_voltage_code = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, adapter_present = 1'b1, loop_on_req = 1'b0, irq;
	logic temp_over_cmp, temp_cold_cmp, temp_hot_cmp, temp_short_cmp;
	logic src_on_cmp, src_off_cmp, load_off_cmp, load_on_cmp;
	logic source_switch_drive, load_switch_drive, high_side_on, charge_allowed;
	int ohm = 10000, dmv = 0, n_errors = 0, comparisons = 0, n;
	int tv[5] = '{200000, 50000, 10000, 2000, 450};
	logic [31:0] te[5] = '{32'h3, 32'h2, 32'h0, 32'h4, 32'hC};
	int dv[8] = '{400, 200, 50, 200, -50, -200, -400, -200};
	logic [1:0] se[8] = '{2'h2, 2'h2, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1};
	charger_status_gate #(.MAX_ON_CYCLES(50), .MIN_OFF_CYCLES(25)) uut (.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .temp_over_cmp,
		.temp_cold_cmp, .temp_hot_cmp, .temp_short_cmp, .src_on_cmp, .src_off_cmp,
		.load_off_cmp, .load_on_cmp, .adapter_present, .loop_on_req, .pack_voltage_code,
		.source_switch_drive, .load_switch_drive, .high_side_on, .charge_allowed, .irq);
	pack_comparators pc (.therm_ohm(ohm), .delta_mv(dmv), .temp_over_cmp, .temp_cold_cmp,
		.temp_hot_cmp, .temp_short_cmp, .src_on_cmp, .src_off_cmp, .load_off_cmp, .load_on_cmp);
	initial forever #20 pclk = ~pclk;
	// ********
	// Tasks
	// ********
	task automatic conclude();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic wt(input int c);
		repeat (c) @(posedge pclk);
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			n_errors++;
			conclude();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk($sformatf("reg %h", a), e, rd & m);
	endtask
	// Counts cycles while the high-side drive keeps one level
	task automatic span(input logic v);
		n = 0;
		while (high_side_on === v && n < 400) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 400) begin
			n_errors++;
			conclude();
		end
	endtask
	// ********
	// Sequence
	// ********
	initial begin
		wt(6);
		presetn <= 1'b1;
		@(posedge pclk);
		rc(chg_pkg::ADDR_MODE, '1, chg_pkg::MODE_RESET);
		rc(chg_pkg::ADDR_MASK, '1, chg_pkg::MASK_RESET);
		rc(chg_pkg::ADDR_TOFF, '1, chg_pkg::TOFF_RESET);
		rc(8'h14, '1, 32'h0);
		chk("slverr", 32'h1, {31'h0, err});
		apb(1'b1, chg_pkg::ADDR_STATUS, '1);
		rc(chg_pkg::ADDR_STATUS, 32'h1F, 32'h0);
		foreach (tv[i]) begin
			ohm <= tv[i];
			wt(8);
			rc(chg_pkg::ADDR_STATUS, 32'hF, te[i]);
		end
		ohm <= 10000;
		wt(8);
		rc(chg_pkg::ADDR_STATUS, 32'h30, 32'h10);
		chk("charge", 32'h0, {31'h0, charge_allowed});
		apb(1'b1, chg_pkg::ADDR_MODE, 32'h8);
		rc(chg_pkg::ADDR_STATUS, 32'h20, 32'h20);
		ohm <= 50000;
		wt(8);
		rc(chg_pkg::ADDR_STATUS, 32'h22, 32'h22);
		apb(1'b1, chg_pkg::ADDR_MODE, 32'hB);
		ohm <= 450;
		wt(8);
		rc(chg_pkg::ADDR_STATUS, 32'h20, 32'h20);
		ohm <= 2000;
		wt(8);
		rc(chg_pkg::ADDR_STATUS, 32'h20, 32'h0);
		ohm <= 10000;
		wt(8);
		apb(1'b1, chg_pkg::ADDR_MODE, 32'h4);
		rc(chg_pkg::ADDR_STATUS, 32'h10, 32'h0);
		apb(1'b1, chg_pkg::ADDR_MODE, 32'h0);
		ohm <= 2000;
		wt(8);
		ohm <= 200000;
		wt(8);
		rc(chg_pkg::ADDR_STATUS, 32'h4010, 32'h0);
		rc(chg_pkg::ADDR_MODE, '1, chg_pkg::MODE_RESET);
		ohm <= 10000;
		wt(8);
		apb(1'b1, chg_pkg::ADDR_IRQ, '1);
		foreach (dv[i]) begin
			dmv <= dv[i];
			wt(8);
			chk("switches", {30'h0, se[i]},
				{30'h0, source_switch_drive, load_switch_drive});
			rc(chg_pkg::ADDR_STATUS, 32'h2000, se[i][1] ? 32'h0 : 32'h2000);
		end
		rc(chg_pkg::ADDR_IRQ, 32'h1, 32'h1);
		chk("irq", 32'h1, {31'h0, irq});
		apb(1'b1, chg_pkg::ADDR_IRQ, '1);
		wt(2);
		chk("irq", 32'h0, {31'h0, irq});
		apb(1'b1, chg_pkg::ADDR_MASK, 32'h1);
		dmv <= 400;
		wt(8);
		rc(chg_pkg::ADDR_IRQ, 32'h1, 32'h1);
		chk("irq", 32'h0, {31'h0, irq});
		// Adapter loss is an unmasked event here
		adapter_present <= 1'b0;
		wt(8);
		rc(chg_pkg::ADDR_STATUS, 32'h8000, 32'h0);
		rc(chg_pkg::ADDR_IRQ, 32'h4, 32'h4);
		chk("irq", 32'h1, {31'h0, irq});
		adapter_present <= 1'b1;
		// Off time is base plus pack code: 30 + 5
		apb(1'b1, chg_pkg::ADDR_TOFF, 32'h1E);
		pack_voltage_code <= 8'h05;
		loop_on_req <= 1'b1;
		span(1'b0);
		span(1'b1);
		chk("on", 32'h32, n);
		span(1'b0);
		chk("off", 32'h23, n);
		loop_on_req <= 1'b0;
		wt(4);
		conclude();
	end
	initial begin
		wt(30000);
		n_errors++;
		conclude();
	end
endmodule
